// File: asr_delay.sv
// Down-counter that times each memory phase in mclk cycles
`timescale 1ns/10ps
module asr_delay (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [asr_pkg::CNT_W-1:0] count,
    // Status
    output logic done
);
    logic [asr_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= asr_pkg::ZERO_CNT;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != asr_pkg::ZERO_CNT) begin
            cnt_reg <= cnt_reg - asr_pkg::ONE_CNT;
        end
    end

    // Done while the count has run out; it must not look at load, since the
    // caller forms load from done and the two would close a loop
    assign done = (cnt_reg == asr_pkg::ZERO_CNT);
endmodule : asr_delay

// File: asr_host.sv
// Host controller that runs read and write cycles on a 16K x 4 async static memory
// ------------------------------------------------------------
// How it works
// - Read: strobe high, select low; memory drives the addressed word.
// - Address is valid before or as select falls for a read.
// - Address changes only while strobe or select is high.
// - Write ends on first of select or strobe rising; recovery follows.
// ------------------------------------------------------------
`timescale 1ns/10ps
module asr_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    // User answer
    output logic rsp_valid,
    output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
    // Memory pins
    output logic sel_n,
    output logic wr_n,
    output logic [asr_pkg::ADDR_W-1:0] word_addr,
    input wire logic [asr_pkg::DATA_W-1:0] shared_data_pins_i,
    output logic [asr_pkg::DATA_W-1:0] shared_data_pins_o,
    output logic shared_data_pins_oe
);
    asr_pkg::asr_state_t state_reg;
    logic write_reg;
    logic load;
    logic [asr_pkg::CNT_W-1:0] count;
    logic done;
    logic [asr_pkg::DATA_W-1:0] din_meta_reg;
    logic [asr_pkg::DATA_W-1:0] din_sync_reg;

    // ------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------
    asr_delay u_delay (
        .mclk(mclk),
        .rst(rst),
        .load(load),
        .count(count),
        .done(done)
    );

    // Setup, read and write reload the timer on the cycle their done is seen, so a phase
    // lasts its count plus one cycle; that cycle is the margin for pin skew

    always_comb begin
        load = 1'b0;
        count = asr_pkg::ZERO_CNT;
        case (state_reg)
            asr_pkg::ASR_IDLE: begin
                if (req_valid) begin
                    load = 1'b1;
                    count = asr_pkg::ONE_CNT;
                end
            end
            asr_pkg::ASR_SETUP: begin
                if (done) begin
                    load = 1'b1;
                    // Sampled data takes two extra cycles through the synchroniser
                    count = write_reg ? asr_pkg::WP_CNT : asr_pkg::RD_CNT + 6'h02;
                end
            end
            asr_pkg::ASR_READ, asr_pkg::ASR_WRITE: begin
                if (done) begin
                    load = 1'b1;
                    count = asr_pkg::HZ_CNT;
                end
            end
            default: begin
                load = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= asr_pkg::ASR_IDLE;
        end else begin
            case (state_reg)
                asr_pkg::ASR_IDLE: begin
                    if (req_valid) begin
                        state_reg <= asr_pkg::ASR_SETUP;
                    end
                end
                asr_pkg::ASR_SETUP: begin
                    if (done) begin
                        state_reg <= write_reg ? asr_pkg::ASR_WRITE : asr_pkg::ASR_READ;
                    end
                end
                asr_pkg::ASR_READ, asr_pkg::ASR_WRITE: begin
                    if (done) begin
                        state_reg <= asr_pkg::ASR_RECOVER;
                    end
                end
                asr_pkg::ASR_RECOVER: begin
                    if (done) begin
                        state_reg <= asr_pkg::ASR_IDLE;
                    end
                end
                default: begin
                    state_reg <= asr_pkg::ASR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request capture: address and data held for the whole access
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            write_reg <= 1'b0;
            word_addr <= 14'h0000;
            shared_data_pins_o <= 4'h0;
        end else if (state_reg == asr_pkg::ASR_IDLE && req_valid) begin
            // Address moves only here, while select and strobe are both high
            write_reg <= req_write;
            word_addr <= req_addr;
            shared_data_pins_o <= req_wdata;
        end
    end

    // ------------------------------------------------------------
    // Memory control pins
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sel_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            case (state_reg)
                asr_pkg::ASR_SETUP: begin
                    // Address has stood two full cycles before select falls
                    if (done) begin
                        sel_n <= 1'b0;
                        wr_n <= !write_reg;
                    end
                end
                asr_pkg::ASR_READ, asr_pkg::ASR_WRITE: begin
                    // Both rise together, ending the write on one edge
                    if (done) begin
                        sel_n <= 1'b1;
                        wr_n <= 1'b1;
                    end
                end
                default: begin
                    sel_n <= 1'b1;
                    wr_n <= 1'b1;
                end
            endcase
        end
    end

    // Strobe and select fall in the same edge, so the memory never turns its
    // outputs on during a write; the data pins are driven only in writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shared_data_pins_oe <= 1'b0;
        end else if (state_reg == asr_pkg::ASR_SETUP && done) begin
            shared_data_pins_oe <= write_reg;
        end else if (state_reg == asr_pkg::ASR_RECOVER) begin
            // Data is held one cycle past the rise of select and strobe, so the
            // memory never latches a word that is already changing
            shared_data_pins_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data synchroniser and answer
    // ------------------------------------------------------------
    // The pins come from an unclocked part and pass two flops before use; the
    // read phase is stretched by two cycles so the sampled word is settled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            din_meta_reg <= 4'h0;
            din_sync_reg <= 4'h0;
        end else begin
            din_meta_reg <= shared_data_pins_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 4'h0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_reg == asr_pkg::ASR_READ && done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= din_sync_reg;
            end else if (state_reg == asr_pkg::ASR_WRITE && done) begin
                rsp_valid <= 1'b1;
            end
        end
    end

    // Ready is only a hint: a request raised while idle is taken at the next
    // edge, so the user must drop it in the cycle the answer shows
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_reg == asr_pkg::ASR_RECOVER && done) ||
                         (state_reg == asr_pkg::ASR_IDLE && !req_valid);
        end
    end
endmodule : asr_host

// File: asr_host_asserts.sv
// Checker: pin-level assertions for the async static memory host controller
`timescale 1ns/10ps
module asr_host_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Watched outputs
    input wire logic rsp_valid,
    input wire logic sel_n,
    input wire logic wr_n,
    input wire logic [asr_pkg::ADDR_W-1:0] word_addr,
    input wire logic shared_data_pins_oe
);
    // ----
    // Memory link properties
    // ----
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_wr_begin; $fell(wr_n) && $fell(sel_n); endsequence
    sequence s_wr_end; $rose(wr_n) && $rose(sel_n) && rsp_valid; endsequence
    sequence s_rd_end; $rose(sel_n) && rsp_valid; endsequence
    property p_addr_hold; !sel_n && $past(!sel_n) |-> $stable(word_addr); endproperty
    property p_addr_setup; $fell(sel_n) |-> $stable(word_addr); endproperty
    property p_addr_move; !$stable(word_addr) |-> sel_n && wr_n; endproperty
    property p_no_clash; !sel_n && wr_n |-> !shared_data_pins_oe; endproperty
    property p_wr_oe; !wr_n |-> !sel_n && shared_data_pins_oe; endproperty
    property p_write_len; s_wr_begin |-> ##20 s_wr_end; endproperty
    property p_read_len; $fell(sel_n) && wr_n |-> ##25 s_rd_end; endproperty
    // Turnaround keeps the memory outputs off the bus before the next access
    property p_recover; $rose(sel_n) |-> sel_n[*8]; endproperty
    // Write data stays on the pins one cycle past the end of the write
    property p_data_hold; $rose(sel_n) && $past(!wr_n) |-> shared_data_pins_oe; endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in access");
    a_addr_setup: assert property (p_addr_setup) else $error("address late");
    a_addr_move: assert property (p_addr_move) else $error("address moved unsafely");
    a_no_clash: assert property (p_no_clash) else $error("host drove during read");
    a_wr_oe: assert property (p_wr_oe) else $error("strobe without select");
    a_write_len: assert property (p_write_len) else $error("write length wrong");
    a_read_len: assert property (p_read_len) else $error("read length wrong");
    a_recover: assert property (p_recover) else $error("recovery too short");
    a_data_hold: assert property (p_data_hold) else $error("data dropped early");
endmodule : asr_host_chk

bind asr_host asr_host_chk u_chk (.mclk(mclk), .rst(rst), .rsp_valid(rsp_valid),
    .sel_n(sel_n), .wr_n(wr_n), .word_addr(word_addr),
    .shared_data_pins_oe(shared_data_pins_oe));

// File: asr_pkg.sv
// Package: constants for the host-side controller of a 16K x 4 async static memory
package asr_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 4;
    localparam int DEPTH = 16384;
    // ------------------------------------------------------------
    // Timing (ns, at 4 ns per mclk)
    // ------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int T_RC_NS = 85;
    localparam int T_WP_NS = 75;
    localparam int T_DW_NS = 35;
    localparam int T_HZ_NS = 40;
    localparam int RD_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HZ_CYC = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
    localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC);
    localparam logic [CNT_W-1:0] HZ_CNT = CNT_W'(HZ_CYC);
    localparam logic [CNT_W-1:0] ONE_CNT = 6'h01;
    localparam logic [CNT_W-1:0] ZERO_CNT = 6'h00;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_SETUP,
        ASR_READ,
        ASR_WRITE,
        ASR_RECOVER
    } asr_state_t;
endpackage : asr_pkg

// File: asr_sram_model.sv
// Behavioural model of the 16K x 4 async static memory
`timescale 1ns/10ps
module asr_sram_model (
    // Memory pins
    input wire logic sel_n,
    input wire logic wr_n,
    input wire logic [asr_pkg::ADDR_W-1:0] word_addr,
    input wire logic [asr_pkg::DATA_W-1:0] data_in,
    output logic [asr_pkg::DATA_W-1:0] data_out,
    output logic driving
);
    logic [asr_pkg::DATA_W-1:0] mem [asr_pkg::DEPTH];
    logic [asr_pkg::DATA_W-1:0] last_out = 4'h0;
    assign driving = !sel_n && wr_n;
    always @(sel_n, wr_n, word_addr, data_in) begin
        if (!sel_n && !wr_n) begin
            mem[word_addr] = data_in;
        end
    end
    // Released pins show the inverse so a stale value never passes
    always @(driving, word_addr) begin
        if (driving) begin
            last_out = mem[word_addr];
            data_out = last_out;
        end else begin
            data_out = ~last_out;
        end
    end
endmodule : asr_sram_model

// File: tb_top.sv
// Testbench: read and write cycles through the host controller into a memory model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic mclk, rst, req_valid, req_write, req_ready, rsp_valid, sel_n, wr_n, oe, drv;
    logic [asr_pkg::ADDR_W-1:0] req_addr, word_addr;
    logic [asr_pkg::DATA_W-1:0] req_wdata, rsp_rdata, pins_o, pins_w, m_out;
    int error_cnt = 0;
    int samples_checked = 0;
    assign pins_w = oe ? pins_o : m_out;
    asr_host dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sel_n(sel_n), .wr_n(wr_n),
        .word_addr(word_addr), .shared_data_pins_i(pins_w), .shared_data_pins_o(pins_o),
        .shared_data_pins_oe(oe));
    asr_sram_model u_mem (.sel_n(sel_n), .wr_n(wr_n), .word_addr(word_addr),
        .data_in(pins_w), .data_out(m_out), .driving(drv));
    // Both sides driving the shared pins at once is a clash
    always @(negedge mclk) begin
        if (rst === 1'b0 && drv === 1'b1) `CHK("clash oe", 1'b0, oe)
    end
    // ----
    // Tasks
    // ----
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic access(input logic wr, input logic [13:0] a, input logic [3:0] d);
        int n;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge mclk);
        if (n == 100) begin
            error_cnt++;
            end_sim();
        end
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        // Held until the answer so the request is taken exactly once
        for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(negedge mclk);
        req_valid = 1'b0;
        if (n == 100) begin
            error_cnt++;
            end_sim();
        end
        // Answer: two setup cycles, the phase, one closing cycle after the take
        `CHK("cycles", wr ? asr_pkg::WP_CYC + 4 : asr_pkg::RD_CYC + 6, n)
        @(negedge mclk);
        `CHK("rsp_valid pulse", 1'b0, rsp_valid)
    endtask : access
    task automatic t_reset();
        `CHK("sel_n", 1'b1, sel_n)
        `CHK("wr_n", 1'b1, wr_n)
        `CHK("oe", 1'b0, oe)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_corners();
        logic [13:0] a [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
        logic [3:0] d [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
        for (int i = 0; i < 4; i++) access(1'b1, a[i], d[i]);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, a[i], 4'h0);
            `CHK("rdata", d[i], rsp_rdata)
        end
        @(negedge mclk);
        `CHK("idle sel_n", 1'b1, sel_n)
        $display("t_corners done");
    endtask : t_corners
    task automatic t_overwrite();
        access(1'b1, 14'h0000, 4'h3);
        access(1'b1, 14'h3FFF, 4'hC);
        access(1'b0, 14'h0000, 4'h0);
        `CHK("rdata low", 4'h3, rsp_rdata)
        access(1'b0, 14'h3FFF, 4'h0);
        `CHK("rdata high", 4'hC, rsp_rdata)
        access(1'b0, 14'h3FFF, 4'h0);
        `CHK("reread", 4'hC, rsp_rdata)
        $display("t_overwrite done");
    endtask : t_overwrite
    // ----
    // Sequence
    // ----
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 14'h0000;
        req_wdata = 4'h0;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_reset();
        t_corners();
        t_overwrite();
        end_sim();
    end
endmodule : tb_top
